// [design/raic_pkg.sv]
// Constants for the RTC interrupt, interval alarm and crystal trim block.
// Assumes an 8-bit special function register port on the processor clock.
package raic_pkg;

   // Register offsets
   localparam logic [7:0] A_CFG = 8'ha1;
   localparam logic [7:0] A_IVAL = 8'ha6;
   localparam logic [7:0] A_IE = 8'ha9;
   localparam logic [7:0] A_KEY = 8'hc1;
   localparam logic [7:0] A_NOM = 8'hf6;
   localparam logic [7:0] A_TMP = 8'hf7;
   localparam logic [7:0] A_PIN = 8'hff;

   // Reset values
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] IVAL_RST = 8'h00;
   localparam logic [7:0] IE_RST = 8'h00;
   localparam logic [7:0] KEY_RST = 8'h00;
   localparam logic [7:0] NOM_RST = 8'h00;
   localparam logic [7:0] TMP_RST = 8'h00;
   localparam logic [7:0] PIN_RST = 8'h00;

   // Field positions
   localparam int CFG_EN = 0;
   localparam int CFG_TS = 1;
   localparam int CFG_SIT = 3;
   localparam int CFG_ALM = 4;
   localparam int CFG_MID = 5;
   localparam int CFG_HR = 6;
   localparam int IE_RTC = 2;
   localparam int PIN_SEL = 5;
   localparam int PIN_CAL = 7;

   // Values and counts
   localparam logic [7:0] KEY_UNLOCK = 8'hea;
   localparam logic [7:0] HOUR_LAST_24 = 8'h17;
   localparam logic [7:0] HOUR_LAST_256 = 8'hff;
   localparam logic [7:0] TICK128_LAST = 8'hff;
   localparam logic [7:0] FAST_MULT = 8'h7d;
   localparam int TRIM_LIM_PPM = 248;
   localparam int PPM_PER_LSB = 2;
   localparam logic signed [8:0] TRIM_MAX = 9'(TRIM_LIM_PPM / PPM_PER_LSB);
   localparam logic signed [20:0] ACC_LIM = 21'(1000000 / PPM_PER_LSB);
   localparam int CAL_TAP [4] = '{14, 5, 12, 7};

endpackage

// [design/raic_trim.sv]
// Digital crystal trim: turns crystal edges into a corrected RTC tick stream.
// Assumes crystal edges are already synchronised to clock.
`timescale 1ns/10ps
`default_nettype none

module raic_trim (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   // Crystal and mode
   input wire logic xtal_edge,
   input wire logic fast,
   input wire logic [7:0] nom,
   input wire logic [7:0] tmp,
   // Corrected tick
   output logic tick
);

   typedef struct packed {
      logic signed [20:0] acc;
      logic [7:0] pend;
      logic tick;
   } raic_trim_s;

   raic_trim_s s;
   raic_trim_s n;
   logic signed [8:0] sum;
   logic signed [8:0] corr;
   logic signed [20:0] accn;
   logic [7:0] add;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      n = s;
      sum = $signed({nom[7], nom}) + $signed({tmp[7], tmp});
      if (sum > raic_pkg::TRIM_MAX) begin
         corr = raic_pkg::TRIM_MAX;
      end else if (sum < -raic_pkg::TRIM_MAX) begin
         corr = -raic_pkg::TRIM_MAX;
      end else begin
         corr = sum;
      end
      accn = s.acc + 21'(corr);
      add = fast ? raic_pkg::FAST_MULT : 8'h01;
      if (accn >= raic_pkg::ACC_LIM) begin
         accn = accn - raic_pkg::ACC_LIM;
         add = add + 8'h01;
      end else if (accn <= -raic_pkg::ACC_LIM) begin
         accn = accn + raic_pkg::ACC_LIM;
         add = add - 8'h01;
      end
      n.tick = (s.pend != 8'h00);
      n.pend = s.pend - {7'h00, n.tick};
      if (xtal_edge) begin
         n.acc = accn;
         n.pend = n.pend + add;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else if (clk_en) begin
         s <= n;
      end
   end

   assign tick = s.tick;

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   property p_sat;
      corr <= raic_pkg::TRIM_MAX && corr >= -raic_pkg::TRIM_MAX;
   endproperty
   a_sat: assert property (p_sat) else $error("trim sum not saturated");

   property p_norm;
      clk_en && xtal_edge && !fast && corr == 9'sd0 && s.pend == 8'h00 |=> s.pend == 8'h01;
   endproperty
   a_norm: assert property (p_norm) else $error("normal edge not one tick");

   property p_fast;
      clk_en && xtal_edge && fast && corr == 9'sd0 && s.pend == 8'h00
         |=> s.pend == raic_pkg::FAST_MULT;
   endproperty
   a_fast: assert property (p_fast) else $error("fast edge not 125 ticks");

endmodule

`default_nettype wire

// [design/raic_core.sv]
// RTC interrupt, interval alarm, crystal trim and calibration output.
// Assumes SFR strobes, hour count and tick inputs on clock; xtal_pin is async.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - One enable bit gates both RTC interrupts
// - Midnight or alarm always sets pending
// - Enabled pending requests vector; acknowledge clears pending
// - Disabled pending holds until enable set
// - Events set flags; software clears them
// - Pending interrupt keeps waking sleeping core
// - Enable feeds selected time base counter
// - Counter match raises alarm flag, pending
// - Periodic mode clears counter, keeps counting
// - Single-shot holds counter after alarm
// - Alarm during deepest sleep wakes core
// - Trim inserts or drops crystal pulses
// - Trim sum of two registers saturates
// - Each trim step is two ppm
// - Calibration pin driven only when enabled
// - Normal select gives 1 or 512 Hz
// - Fast select 500 or 16000, active only
// - Fast mode clocks RTC 125 times faster
// - Hour wrap from 23 or 255 gives midnight
// - Enable, time base, single-shot and interval apply on 128 Hz tick
module raic_core (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   // Special function register port
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   // Crystal and timekeeping
   input wire logic xtal_pin,
   input wire logic [7:0] hour_count,
   input wire logic sec_tick,
   input wire logic min_tick,
   input wire logic hour_tick,
   output logic rtc_tick,
   // Processor core
   input wire logic irq_ack,
   input wire logic full_power_mode,
   input wire logic battery_power_mode,
   input wire logic sleep_power_mode,
   output logic irq_req,
   output logic wake_req,
   // Calibration pin
   output logic shared_cal_output_pin_o,
   output logic shared_cal_output_pin_oe
);

   typedef struct packed {
      logic [2:0] xs;
      logic [7:0] cfg;
      logic [3:0] cfr;
      logic [7:0] ival;
      logic [7:0] ivr;
      logic [7:0] ie;
      logic [7:0] key;
      logic [7:0] nom;
      logic [7:0] tmp;
      logic [7:0] pin;
      logic mid;
      logic alm;
      logic pend;
      logic held;
      logic [7:0] cnt;
      logic [7:0] hprev;
      logic [14:0] div;
      logic [7:0] rdata;
      logic irq;
      logic wake;
      logic cal;
      logic oe;
   } raic_core_s;

   localparam raic_core_s ST_RST = '{
      cfg: raic_pkg::CFG_RST,
      ival: raic_pkg::IVAL_RST,
      ie: raic_pkg::IE_RST,
      key: raic_pkg::KEY_RST,
      nom: raic_pkg::NOM_RST,
      tmp: raic_pkg::TMP_RST,
      pin: raic_pkg::PIN_RST,
      default: '0
   };

   raic_core_s s;
   raic_core_s n;
   logic xedge;
   logic tick128;
   logic tb;
   logic mid_ev;
   logic alm_ev;
   logic fast;
   logic wcfg;
   logic tick;

   ////////////////////////////////////////////////////////////////////////////////
   // Crystal trim and tick generation
   raic_trim u_trim (
      .clock(clock),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .xtal_edge(xedge),
      .fast(fast),
      .nom(s.nom),
      .tmp(s.tmp),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      n = s;
      n.xs = {s.xs[1:0], xtal_pin};
      xedge = s.xs[1] && !s.xs[2];
      fast = s.pin[raic_pkg::PIN_SEL + 1] && (full_power_mode || battery_power_mode)
         && !sleep_power_mode;
      wcfg = sfr_wr && sfr_addr == raic_pkg::A_CFG;
      // Register writes
      if (sfr_wr) begin
         case (sfr_addr)
            raic_pkg::A_CFG: n.cfg = sfr_wdata;
            raic_pkg::A_IVAL: n.ival = sfr_wdata;
            raic_pkg::A_IE: n.ie = sfr_wdata;
            raic_pkg::A_KEY: n.key = sfr_wdata;
            raic_pkg::A_NOM: n.nom = sfr_wdata;
            raic_pkg::A_TMP: n.tmp = sfr_wdata;
            raic_pkg::A_PIN: begin
               if (s.key == raic_pkg::KEY_UNLOCK) begin
                  n.pin = sfr_wdata;
               end
            end
            default: ;
         endcase
         if (sfr_addr != raic_pkg::A_KEY) begin
            n.key = raic_pkg::KEY_RST;
         end
      end
      // 128 Hz transfer into the RTC side
      n.div = tick ? s.div + 15'h0001 : s.div;
      tick128 = tick && s.div[7:0] == raic_pkg::TICK128_LAST;
      if (tick128) begin
         n.cfr = s.cfg[3:0];
         n.ivr = s.ival;
      end
      // Midnight detection
      n.hprev = hour_count;
      mid_ev = hour_count == 8'h00 && s.hprev == (s.cfg[raic_pkg::CFG_HR] ?
         raic_pkg::HOUR_LAST_256 : raic_pkg::HOUR_LAST_24);
      // Interval timer
      case (s.cfr[raic_pkg::CFG_TS +: 2])
         2'h0: tb = tick128;
         2'h1: tb = sec_tick;
         2'h2: tb = min_tick;
         2'h3: tb = hour_tick;
         default: tb = 1'b0;
      endcase
      alm_ev = 1'b0;
      if (!s.cfr[raic_pkg::CFG_EN]) begin
         n.cnt = 8'h00;
         n.held = 1'b0;
      end else if (tb && !s.held) begin
         if (s.cnt == s.ivr) begin
            alm_ev = 1'b1;
            n.cnt = 8'h00;
            n.held = s.cfr[raic_pkg::CFG_SIT];
         end else begin
            n.cnt = s.cnt + 8'h01;
         end
      end
      // Flags: software clears by writing zero, events win
      if (wcfg) begin
         n.mid = s.mid && sfr_wdata[raic_pkg::CFG_MID];
         n.alm = s.alm && sfr_wdata[raic_pkg::CFG_ALM];
      end
      if (mid_ev) begin
         n.mid = 1'b1;
      end
      if (alm_ev) begin
         n.alm = 1'b1;
      end
      // Pending interrupt, request and wake
      if (irq_ack) begin
         n.pend = 1'b0;
      end
      if (mid_ev || alm_ev) begin
         n.pend = 1'b1;
      end
      n.irq = n.pend && n.ie[raic_pkg::IE_RTC];
      n.wake = n.pend && sleep_power_mode;
      // Calibration output
      n.oe = n.pin[raic_pkg::PIN_CAL];
      n.cal = n.oe && s.div[raic_pkg::CAL_TAP[s.pin[raic_pkg::PIN_SEL +: 2]]];
      // Register reads
      n.rdata = 8'h00;
      if (sfr_rd) begin
         case (sfr_addr)
            raic_pkg::A_CFG: n.rdata = {1'b0, s.cfg[raic_pkg::CFG_HR], s.mid, s.alm,
               s.cfg[3:1], s.cfr[raic_pkg::CFG_EN]};
            raic_pkg::A_IVAL: n.rdata = s.ival;
            raic_pkg::A_IE: n.rdata = s.ie;
            raic_pkg::A_KEY: n.rdata = s.key;
            raic_pkg::A_NOM: n.rdata = s.nom;
            raic_pkg::A_TMP: n.rdata = s.tmp;
            raic_pkg::A_PIN: n.rdata = s.pin;
            default: n.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s <= ST_RST;
      end else if (clk_en) begin
         s <= n;
      end
   end

   assign sfr_rdata = s.rdata;
   assign rtc_tick = tick;
   assign irq_req = s.irq;
   assign wake_req = s.wake;
   assign shared_cal_output_pin_o = s.cal;
   assign shared_cal_output_pin_oe = s.oe;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_alarm;
      clk_en && alm_ev;
   endsequence

   sequence s_quiet;
      !mid_ev && !alm_ev;
   endsequence

   property p_alarm;
      s_alarm |=> s.alm && s.pend;
   endproperty
   a_alarm: assert property (p_alarm) else $error("alarm did not flag");

   property p_periodic;
      s_alarm ##0 !s.cfr[raic_pkg::CFG_SIT] |=> s.cnt == 8'h00 && !s.held;
   endproperty
   a_periodic: assert property (p_periodic) else $error("no periodic restart");

   property p_single;
      s_alarm ##0 s.cfr[raic_pkg::CFG_SIT] |=> s.held && s.cnt == 8'h00;
   endproperty
   a_single: assert property (p_single) else $error("single shot not held");

   property p_midnight;
      clk_en && mid_ev |=> s.mid && s.pend;
   endproperty
   a_midnight: assert property (p_midnight) else $error("midnight lost");

   property p_hold;
      clk_en && s.pend && !irq_ack && !s.ie[raic_pkg::IE_RTC] && !sfr_wr |=> s.pend && !irq_req;
   endproperty
   a_hold: assert property (p_hold) else $error("pending not held");

   property p_vector;
      clk_en && irq_ack ##0 s_quiet |=> !s.pend && !irq_req;
   endproperty
   a_vector: assert property (p_vector) else $error("ack did not clear");

   property p_wake;
      clk_en && s.pend && sleep_power_mode && !irq_ack |=> wake_req;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake while pending");

   property p_flagwr;
      clk_en && wcfg && !s.alm && !alm_ev |=> !s.alm;
   endproperty
   a_flagwr: assert property (p_flagwr) else $error("write set alarm flag");

   property p_calpin;
      !s.pin[raic_pkg::PIN_CAL] |-> !shared_cal_output_pin_oe && !shared_cal_output_pin_o;
   endproperty
   a_calpin: assert property (p_calpin) else $error("cal pin driven");

   property p_sync;
      clk_en && tick128 |=> s.cfr == $past(s.cfg[3:0]) && s.ivr == $past(s.ival);
   endproperty
   a_sync: assert property (p_sync) else $error("128 Hz transfer missed");

endmodule

`default_nettype wire

// [testbench/tb_rtc_alarm_irq_calibration.sv]
// Self-checking bench for the RTC interrupt, interval alarm and trim block.
// Assumes raic_pkg and raic_core are compiled first; the bench drives every port.
`timescale 1ns/10ps
`default_nettype none

module tb_rtc_alarm_irq_calibration;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic [7:0] sfr_wdata = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_rdata;
   logic xtal_pin = 1'b0;
   logic [7:0] hour_count = 8'h00;
   logic sec_tick = 1'b0;
   logic min_tick = 1'b0;
   logic hour_tick = 1'b0;
   logic rtc_tick;
   logic irq_ack = 1'b0;
   logic full_pm = 1'b0;
   logic bat_pm = 1'b0;
   logic sleep_pm = 1'b0;
   logic irq_req;
   logic wake_req;
   logic pin_o;
   logic pin_oe;
   int xph = 0;
   int err_total = 0;
   int comparisons = 0;
   logic [7:0] rv;
   int n;
   logic [2:0] tb_sel = 3'b001;

   ////////////////////////////////////////////////////////////////////////
   always #50 clock = ~clock;

   // Crystal stand-in: one rising edge every 300 clocks
   always @(posedge clock) begin
      xph <= (xph == 299) ? 0 : xph + 1;
      xtal_pin <= (xph < 150);
   end

   raic_core i_raic_core (
      .clock(clock), .rst_n(rst_n), .clk_en(1'b1),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
      .xtal_pin(xtal_pin), .hour_count(hour_count), .sec_tick(sec_tick),
      .min_tick(min_tick), .hour_tick(hour_tick), .rtc_tick(rtc_tick),
      .irq_ack(irq_ack), .full_power_mode(full_pm), .battery_power_mode(bat_pm),
      .sleep_power_mode(sleep_pm), .irq_req(irq_req), .wake_req(wake_req),
      .shared_cal_output_pin_o(pin_o), .shared_cal_output_pin_oe(pin_oe)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      if (err_total == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clock);
      sfr_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge clock);
      sfr_rd <= 1'b0;
      #1 d = sfr_rdata;
   endtask

   task automatic hour_step(input logic [7:0] from);
      @(posedge clock);
      hour_count <= from;
      @(posedge clock);
      hour_count <= 8'h00;
      repeat (3) @(posedge clock);
   endtask

   task automatic ack();
      @(posedge clock);
      irq_ack <= 1'b1;
      @(posedge clock);
      irq_ack <= 1'b0;
      repeat (2) @(posedge clock);
   endtask

   task automatic pulses(input int k);
      repeat (k) begin
         @(posedge clock);
         {hour_tick, min_tick, sec_tick} <= tb_sel;
         @(posedge clock);
         {hour_tick, min_tick, sec_tick} <= 3'b000;
         repeat (3) @(posedge clock);
      end
   endtask

   // Counts corrected ticks over ten crystal periods, starting mid-gap
   task automatic count_ticks(output int cnt);
      cnt = 0;
      for (int i = 0; i < 400 && xph != 200; i++) @(posedge clock);
      if (xph != 200) begin
         chk("crystal phase", 16'(xph), 16'd200);
         complete_run();
      end
      repeat (3000) begin
         @(posedge clock);
         #1 if (rtc_tick === 1'b1) cnt++;
      end
   endtask

   // Waits one 128 Hz period, counted as 256 corrected ticks
   task automatic wait_period();
      int k;
      k = 0;
      for (int i = 0; i < 2000 && k < 256; i++) begin
         @(posedge clock);
         #1 if (rtc_tick === 1'b1) k++;
      end
      chk("period ticks", 16'(k), 16'd256);
      if (k < 256) complete_run();
   endtask

   // Counts corrected ticks between two rising edges of the calibration pin;
   // ticks are delayed two cycles to line up with the registered pin
   task automatic cal_period(output int cnt);
      logic p0;
      logic [1:0] td;
      int rises;
      cnt = 0;
      rises = 0;
      td = 2'b00;
      p0 = pin_o;
      for (int i = 0; i < 4000 && rises < 2; i++) begin
         @(posedge clock);
         #1 if (rises == 1 && td[1]) cnt++;
         if (pin_o && !p0) rises++;
         td = {td[0], rtc_tick};
         p0 = pin_o;
      end
      chk("cal edges", 16'(rises), 16'd2);
      if (rises < 2) complete_run();
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rd(raic_pkg::A_CFG, rv); chk("cfg reset", rv, raic_pkg::CFG_RST);
      rd(raic_pkg::A_IE, rv); chk("ie reset", rv, raic_pkg::IE_RST);
      rd(raic_pkg::A_PIN, rv); chk("pin reset", rv, raic_pkg::PIN_RST);
      rd(8'h10, rv); chk("unmapped", rv, 8'h00);
      wr(raic_pkg::A_NOM, 8'h83);
      wr(raic_pkg::A_TMP, 8'h7f);
      rd(raic_pkg::A_NOM, rv); chk("nom", rv, 8'h83);
      rd(raic_pkg::A_TMP, rv); chk("tmp", rv, 8'h7f);
      wr(raic_pkg::A_NOM, 8'h00);
      wr(raic_pkg::A_TMP, 8'h00);
   endtask

   task automatic t_midnight();
      wr(raic_pkg::A_CFG, 8'h40);
      hour_step(8'h17);
      rd(raic_pkg::A_CFG, rv); chk("no mid 256h", rv, 8'h40);
      hour_step(8'hff);
      rd(raic_pkg::A_CFG, rv); chk("mid 256h", rv, 8'h60);
      ack();
      wr(raic_pkg::A_CFG, 8'h00);
      hour_step(8'h17);
      rd(raic_pkg::A_CFG, rv); chk("mid 24h", rv, 8'h20);
      chk("irq disabled", irq_req, 1'b0);
      sleep_pm <= 1'b1;
      repeat (3) @(posedge clock);
      chk("wake", wake_req, 1'b1);
      wr(raic_pkg::A_IE, 8'h04);
      repeat (2) @(posedge clock);
      chk("irq enabled", irq_req, 1'b1);
      ack();
      chk("irq acked", irq_req, 1'b0);
      chk("wake acked", wake_req, 1'b0);
      sleep_pm <= 1'b0;
      wr(raic_pkg::A_CFG, 8'h20);
      rd(raic_pkg::A_CFG, rv); chk("flag kept", rv, 8'h20);
      chk("no event on write", irq_req, 1'b0);
      wr(raic_pkg::A_CFG, 8'h00);
      rd(raic_pkg::A_CFG, rv); chk("flag cleared", rv, 8'h00);
   endtask

   task automatic t_pin_fast();
      wr(raic_pkg::A_PIN, 8'hc0);
      repeat (2) @(posedge clock);
      chk("pin locked", pin_oe, 1'b0);
      wr(raic_pkg::A_KEY, raic_pkg::KEY_UNLOCK);
      wr(raic_pkg::A_PIN, 8'hc0);
      repeat (2) @(posedge clock);
      chk("pin oe", pin_oe, 1'b1);
      count_ticks(n);
      chk("normal ticks", 16'(n), 16'd10);
      full_pm <= 1'b1;
      count_ticks(n);
      chk("fast ticks", 16'(n), 16'd1250);
      full_pm <= 1'b0;
      bat_pm <= 1'b1;
      count_ticks(n);
      chk("fast battery", 16'(n), 16'd1250);
      wr(raic_pkg::A_KEY, raic_pkg::KEY_UNLOCK);
      wr(raic_pkg::A_PIN, 8'he0);
      repeat (3) @(posedge clock);
      cal_period(n);
      // Fast rate 125 x 32768 ticks/s over 16000 Hz
      chk("cal 16k period", 16'(n), 16'd256);
      sleep_pm <= 1'b1;
      count_ticks(n);
      chk("fast in sleep", 16'(n), 16'd10);
      sleep_pm <= 1'b0;
   endtask

   task automatic t_interval();
      wr(raic_pkg::A_IVAL, 8'h02);
      wait_period();
      wr(raic_pkg::A_CFG, 8'h03);
      rv = 8'h00;
      for (int i = 0; i < 200 && rv[0] !== 1'b1; i++) begin
         repeat (20) @(posedge clock);
         rd(raic_pkg::A_CFG, rv);
      end
      chk("enable applied", rv, 8'h03);
      if (rv[0] !== 1'b1) complete_run();
      pulses(2);
      rd(raic_pkg::A_CFG, rv); chk("no alarm yet", rv[4], 1'b0);
      pulses(1);
      rd(raic_pkg::A_CFG, rv); chk("alarm", rv[4], 1'b1);
      chk("alarm irq", irq_req, 1'b1);
      ack();
      wr(raic_pkg::A_CFG, 8'h03);
      pulses(2);
      rd(raic_pkg::A_CFG, rv); chk("periodic gap", rv[4], 1'b0);
      pulses(1);
      rd(raic_pkg::A_CFG, rv); chk("periodic alarm", rv[4], 1'b1);
      ack();
      wr(raic_pkg::A_CFG, 8'h0b);
      repeat (2500) @(posedge clock);
      sleep_pm <= 1'b1;
      pulses(3);
      chk("alarm wakes", wake_req, 1'b1);
      ack();
      sleep_pm <= 1'b0;
      wr(raic_pkg::A_CFG, 8'h0b);
      pulses(6);
      rd(raic_pkg::A_CFG, rv); chk("single shot", rv[4], 1'b0);
      chk("single shot irq", irq_req, 1'b0);
   endtask

   // Time base change: disable, confirm, set base, then alarm on that base
   task automatic t_timebase(input logic [7:0] cfg, input logic [2:0] sel);
      wr(raic_pkg::A_CFG, 8'h00);
      wait_period();
      rv = 8'hff;
      for (int i = 0; i < 4 && rv[0] !== 1'b0; i++) begin
         rd(raic_pkg::A_CFG, rv);
         if (rv[0] !== 1'b0) wait_period();
      end
      chk("disable seen", rv[0], 1'b0);
      if (rv[0] !== 1'b0) complete_run();
      wr(raic_pkg::A_CFG, cfg);
      repeat (2) wait_period();
      rd(raic_pkg::A_CFG, rv); chk("base applied", rv, cfg);
      if (sel == 3'b000) begin
         repeat (3) wait_period();
      end else begin
         tb_sel = 3'b001;
         pulses(4);
         rd(raic_pkg::A_CFG, rv); chk("other base", rv[4], 1'b0);
         tb_sel = sel;
         pulses(2);
         rd(raic_pkg::A_CFG, rv); chk("base gap", rv[4], 1'b0);
         pulses(1);
         tb_sel = 3'b001;
      end
      rd(raic_pkg::A_CFG, rv); chk("base alarm", rv[4], 1'b1);
      ack();
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      t_regs();
      t_midnight();
      t_pin_fast();
      t_interval();
      t_timebase(8'h05, 3'b010);
      t_timebase(8'h07, 3'b100);
      t_timebase(8'h01, 3'b000);
      complete_run();
   end
endmodule

`default_nettype wire
